// File: logic/drce_exec.sv
// Read command executor: decode, disc read, sector and diagnostic paths
// Summary of operation
// - Hold channel end and device end until every area's ECC check ends.
// - Overrun or check: try command retry, else end with unit check.
// - Code 02 only: no retry for a correctable data error, burst of eleven bytes or less.
// - Attach a generated parity bit to every byte sent to the channel.
// - Read count sends at most eight count bytes per attempt; initial status zero.
// - Code 12 hex is read count, 92 hex its multi-track form.
// - Code 1A hex is read home address, 9A hex its multi-track form.
// - Read home address sends five bytes: flag, cylinder, head.
// - Code 02 seeks cylinder 0 track 0, waits index, reads record one.
// - Code 22 hex returns one sector byte, value 0 to 127.
// - Power-on or system reset since last record makes the sector zero.
// - Sector is last overflow segment, last record or last set sector.
// - Read sector clears the drive's rotational orientation.
// - Read sector ends only after the sector byte reached the channel.
// - Diagnostic load copies 668 flexible disc bytes to control storage.
// - Diagnostic load: channel end on decode, device end after storing.
// - Flexible disc track follows the count of diagnostic loads.
// - Start, seek and read lines follow the load's control byte.
// - Diagnostic status read sends 668 stored bytes plus status bytes.
`timescale 1ns/1ps
module drce_exec #(
	parameter int MAX_RETRY  = 1,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                            CLK_SYS,
	input  wire logic                            RST,
	input  wire logic                            CE,
	input  wire logic                            CMD_VALID,
	output logic                                 CMD_READY,
	input  wire drce_pkg::drce_cmd_type          CMD,
	output logic                                 DRV_REQ,
	output drce_pkg::drce_drv_op_type            DRV_OP,
	output logic                                 DRV_MULTI_TRACK,
	output logic [drce_pkg::DRIVE_W-1:0]         DRV_SELECT,
	input  wire logic                            DRV_DONE,
	input  wire logic                            INDEX_PIN,
	input  wire logic                            DISC_VALID,
	output logic                                 DISC_READY,
	input  wire logic [7:0]                      DISC_DATA,
	input  wire logic                            AREA_END,
	input  wire logic                            AREA_LAST,
	input  wire logic                            ECC_ERR,
	input  wire logic [7:0]                      ECC_BURST,
	input  wire logic                            OVERRUN,
	input  wire logic                            RETRY_EN,
	input  wire logic                            REC_DONE,
	input  wire logic [drce_pkg::DRIVE_W-1:0]    REC_DRIVE,
	input  wire logic [6:0]                      REC_SECTOR,
	input  wire logic                            REC_MORE_SEGMENTS,
	input  wire logic                            SET_SECTOR_VALID,
	input  wire logic [drce_pkg::DRIVE_W-1:0]    SET_SECTOR_DRIVE,
	input  wire logic [6:0]                      SET_SECTOR_VALUE,
	input  wire logic [drce_pkg::NUM_DRIVES-1:0] DRV_POWER_ON,
	output logic [drce_pkg::NUM_DRIVES-1:0]      ORIENT_VALID,
	output logic                                 FD_START,
	output logic                                 FD_SEEK,
	output logic                                 FD_READ,
	output logic [7:0]                           FD_TRACK,
	input  wire logic                            FD_VALID,
	input  wire logic [7:0]                      FD_DATA,
	input  wire logic [7:0]                      DRIVE_STATUS,
	input  wire logic [7:0]                      CU_STATUS,
	output logic                                 CHAN_VALID,
	input  wire logic                            CHAN_READY,
	output drce_pkg::drce_chan_byte_type         CHAN_BYTE,
	output logic                                 STAT_VALID,
	output drce_pkg::drce_status_type            STAT
);
	typedef enum {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT_SEEK,
		ST_WAIT_INDEX,
		ST_READ,
		ST_SECT,
		ST_DL_READ,
		ST_DS_SEND,
		ST_DRAIN
	} drce_state_type;

	localparam int ND = drce_pkg::NUM_DRIVES;

	initial begin
		if (MAX_RETRY < 0 || MAX_RETRY > 3)
			$error("drce_exec: MAX_RETRY must lie in 0..3");
		if (ND != (1 << drce_pkg::DRIVE_W))
			$error("drce_exec: drive count must match select width");
	end

	// Odd parity, as the channel checks it
	function automatic drce_pkg::drce_chan_byte_type with_par(
		input logic [7:0] d
	);
		drce_pkg::drce_chan_byte_type b;
		b.data   = d;
		b.parity = ~^d;
		return b;
	endfunction

	drce_state_type                   state_q;
	drce_pkg::drce_drv_op_type        op_q;
	logic [7:0]                       code_q;
	logic [drce_pkg::DRIVE_W-1:0]     drive_q;
	logic [drce_pkg::IDX_W-1:0]       limit_q;
	logic [drce_pkg::IDX_W-1:0]       cnt_q;
	logic [1:0]                       retry_q;
	logic                             fail_q;
	logic                             err_q;
	logic                             ipl_q;
	logic [6:0]                       sect_q [ND];
	logic [ND-1:0]                    orient_q;
	logic [7:0]                       dstore_q [drce_pkg::DIAG_WORDS];
	logic [7:0]                       track_q;
	logic [2:0]                       fd_ctrl_q;
	logic                             idx_s1_q;
	logic                             idx_s2_q;
	logic                             idx_s3_q;
	logic                             index_edge;
	logic [7:0]                       base_code;
	logic                             fifo_in_valid;
	logic                             fifo_in_ready;
	drce_pkg::drce_chan_byte_type     fifo_in_data;
	logic                             fifo_empty;
	logic                             take_disc;
	logic                             take_fd;
	logic                             area_bad;
	logic                             correctable;
	logic                             can_retry;
	logic [7:0]                       ds_byte;

	assign base_code  = CMD.code & ~drce_pkg::MT_MASK;
	assign index_edge = idx_s2_q && !idx_s3_q;
	assign CMD_READY  = CE && (state_q == ST_IDLE);
	assign DISC_READY = CE && (state_q == ST_READ) && fifo_in_ready;
	assign take_disc  = DISC_READY && DISC_VALID;
	assign take_fd    = CE && (state_q == ST_DL_READ) && FD_VALID;
	assign area_bad   = err_q || ECC_ERR || OVERRUN;
	assign correctable = ipl_q && ECC_ERR && !err_q && !OVERRUN &&
		(ECC_BURST <= drce_pkg::CORR_BURST_MAX);
	assign can_retry  = RETRY_EN && !correctable &&
		(retry_q < 2'(MAX_RETRY));
	assign ORIENT_VALID = orient_q;
	assign FD_START = fd_ctrl_q[drce_pkg::CTRL_START];
	assign FD_SEEK  = fd_ctrl_q[drce_pkg::CTRL_SEEK];
	assign FD_READ  = fd_ctrl_q[drce_pkg::CTRL_READ];
	assign FD_TRACK = track_q;
	assign DRV_OP   = op_q;
	assign DRV_SELECT = drive_q;
	assign DRV_MULTI_TRACK = code_q[7];

	// Diagnostic image first, then drive and control unit status
	always_comb begin
		if (cnt_q < drce_pkg::LEN_DIAG)
			ds_byte = dstore_q[cnt_q];
		else if (cnt_q == drce_pkg::LEN_DIAG)
			ds_byte = DRIVE_STATUS;
		else
			ds_byte = CU_STATUS;
	end

	always_comb begin
		fifo_in_valid = 1'b0;
		fifo_in_data  = with_par(DISC_DATA);
		unique case (state_q)
			ST_READ: begin
				fifo_in_valid = take_disc &&
					(limit_q == drce_pkg::LEN_NONE || cnt_q < limit_q);
			end
			ST_SECT: begin
				fifo_in_valid = 1'b1;
				fifo_in_data  = with_par({1'b0, sect_q[drive_q]});
			end
			ST_DS_SEND: begin
				fifo_in_valid = (cnt_q < drce_pkg::LEN_DSTAT);
				fifo_in_data  = with_par(ds_byte);
			end
			default: begin
				fifo_in_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			idx_s1_q <= 1'b0;
			idx_s2_q <= 1'b0;
			idx_s3_q <= 1'b0;
		end else if (CE) begin
			idx_s1_q <= INDEX_PIN;
			idx_s2_q <= idx_s1_q;
			idx_s3_q <= idx_s2_q;
		end
	end

	// Command sequencing
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_q    <= ST_IDLE;
			op_q       <= drce_pkg::DRV_READ_COUNT;
			code_q     <= '0;
			drive_q    <= '0;
			limit_q    <= drce_pkg::LEN_NONE;
			cnt_q      <= drce_pkg::IDX_ZERO;
			retry_q    <= '0;
			fail_q     <= 1'b0;
			err_q      <= 1'b0;
			ipl_q      <= 1'b0;
			DRV_REQ    <= 1'b0;
			STAT_VALID <= 1'b0;
			STAT       <= '0;
		end else if (CE) begin
			DRV_REQ    <= 1'b0;
			STAT_VALID <= 1'b0;
			STAT       <= '0;
			if (fifo_in_valid && fifo_in_ready)
				cnt_q <= cnt_q + drce_pkg::IDX_ONE;
			unique case (state_q)
				ST_IDLE: begin
					if (CMD_VALID) begin
						code_q  <= CMD.code;
						drive_q <= CMD.drive;
						cnt_q   <= drce_pkg::IDX_ZERO;
						retry_q <= '0;
						fail_q  <= 1'b0;
						err_q   <= 1'b0;
						ipl_q   <= 1'b0;
						limit_q <= drce_pkg::LEN_NONE;
						if (base_code == drce_pkg::OP_RD_COUNT) begin
							op_q    <= drce_pkg::DRV_READ_COUNT;
							limit_q <= drce_pkg::LEN_COUNT;
							state_q <= ST_ISSUE;
						end else if (base_code == drce_pkg::OP_RD_HA) begin
							op_q    <= drce_pkg::DRV_READ_HA;
							limit_q <= drce_pkg::LEN_HA;
							state_q <= ST_ISSUE;
						end else if (CMD.code == drce_pkg::OP_RD_IPL) begin
							op_q    <= drce_pkg::DRV_SEEK_HOME;
							ipl_q   <= 1'b1;
							state_q <= ST_ISSUE;
						end else if (CMD.code == drce_pkg::OP_RD_SECTOR) begin
							state_q <= ST_SECT;
						end else if (CMD.code == drce_pkg::OP_DIAG_LOAD) begin
							STAT_VALID <= 1'b1;
							STAT.ce    <= 1'b1;
							state_q    <= ST_DL_READ;
						end else if (CMD.code == drce_pkg::OP_DIAG_STAT1) begin
							state_q <= ST_DS_SEND;
						end else begin
							STAT_VALID <= 1'b1;
							STAT.ce    <= 1'b1;
							STAT.de    <= 1'b1;
							STAT.uc    <= 1'b1;
						end
					end
				end
				ST_ISSUE: begin
					DRV_REQ <= 1'b1;
					cnt_q   <= drce_pkg::IDX_ZERO;
					err_q   <= 1'b0;
					if (op_q == drce_pkg::DRV_SEEK_HOME)
						state_q <= ST_WAIT_SEEK;
					else
						state_q <= ST_READ;
				end
				ST_WAIT_SEEK: begin
					if (DRV_DONE)
						state_q <= ST_WAIT_INDEX;
				end
				ST_WAIT_INDEX: begin
					if (index_edge) begin
						op_q    <= drce_pkg::DRV_READ_R1;
						state_q <= ST_ISSUE;
					end
				end
				ST_READ: begin
					if (OVERRUN)
						err_q <= 1'b1;
					if (AREA_END && area_bad) begin
						if (can_retry) begin
							// Retry relocates the record; bytes already sent stay
							retry_q    <= retry_q + drce_pkg::RETRY_STEP;
							STAT_VALID <= 1'b1;
							STAT.retry <= 1'b1;
							op_q       <= ipl_q ? drce_pkg::DRV_SEEK_HOME : op_q;
							state_q    <= ST_ISSUE;
						end else begin
							fail_q  <= 1'b1;
							state_q <= ST_DRAIN;
						end
					end else if (AREA_END && AREA_LAST) begin
						state_q <= ST_DRAIN;
					end
				end
				ST_SECT: begin
					if (fifo_in_ready)
						state_q <= ST_DRAIN;
				end
				ST_DL_READ: begin
					if (take_fd && cnt_q == drce_pkg::LEN_DIAG - 1'b1) begin
						STAT_VALID <= 1'b1;
						STAT.de    <= 1'b1;
						state_q    <= ST_IDLE;
					end
					if (take_fd)
						cnt_q <= cnt_q + drce_pkg::IDX_ONE;
				end
				ST_DS_SEND: begin
					if (cnt_q == drce_pkg::LEN_DSTAT)
						state_q <= ST_DRAIN;
				end
				ST_DRAIN: begin
					// Ending waits for the channel to take every queued byte
					if (fifo_empty) begin
						STAT_VALID <= 1'b1;
						STAT.ce    <= 1'b1;
						STAT.de    <= 1'b1;
						STAT.uc    <= fail_q;
						state_q    <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Per-drive sector memory; a record end wins over a set sector load
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int i = 0; i < ND; i++)
				sect_q[i] <= drce_pkg::SECTOR_RESET;
			orient_q <= '0;
		end else if (CE) begin
			for (int i = 0; i < ND; i++) begin
				if (DRV_POWER_ON[i]) begin
					sect_q[i]   <= drce_pkg::SECTOR_RESET;
					orient_q[i] <= 1'b0;
				end else if (REC_DONE && !REC_MORE_SEGMENTS &&
						REC_DRIVE == i[drce_pkg::DRIVE_W-1:0]) begin
					sect_q[i]   <= REC_SECTOR;
					orient_q[i] <= 1'b1;
				end else if (SET_SECTOR_VALID &&
						SET_SECTOR_DRIVE == i[drce_pkg::DRIVE_W-1:0]) begin
					sect_q[i]   <= SET_SECTOR_VALUE;
					orient_q[i] <= 1'b1;
				end else if (state_q == ST_SECT && fifo_in_ready &&
						drive_q == i[drce_pkg::DRIVE_W-1:0]) begin
					orient_q[i] <= 1'b0;
				end
			end
		end
	end

	// Flexible disc control and track position
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			track_q   <= drce_pkg::TRACK_RESET;
			fd_ctrl_q <= '0;
		end else if (CE) begin
			if (CMD_READY && CMD_VALID &&
					CMD.code == drce_pkg::OP_DIAG_LOAD) begin
				track_q   <= track_q + drce_pkg::TRACK_STEP;
				fd_ctrl_q <= CMD.ctrl[2:0];
			end else if (state_q != ST_DL_READ) begin
				fd_ctrl_q <= '0;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (CE && take_fd && cnt_q < drce_pkg::LEN_DIAG)
			dstore_q[cnt_q] <= FD_DATA;
	end

	drce_fifo #(
		.WIDTH ($bits(drce_pkg::drce_chan_byte_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst       (RST),
		.ce        (CE),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (CHAN_VALID),
		.out_ready (CHAN_READY),
		.out_data  (CHAN_BYTE),
		.empty     (fifo_empty)
	);
endmodule

// File: logic/drce_fifo.sv
// Byte FIFO between the read path and the channel
`timescale 1ns/1ps
module drce_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  empty
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("drce_fifo: DEPTH must be a power of two >= 2");
	end

	assign empty     = (cnt_q == '0);
	assign in_ready  = ce && (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = ce && !empty;
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// File: shared/drce_pkg.sv
// Shared constants and types of the read command executor
package drce_pkg;
	localparam logic [7:0] OP_RD_COUNT   = 8'h12;
	localparam logic [7:0] OP_RD_HA      = 8'h1A;
	localparam logic [7:0] OP_RD_IPL     = 8'h02;
	localparam logic [7:0] OP_RD_SECTOR  = 8'h22;
	localparam logic [7:0] OP_DIAG_LOAD  = 8'h53;
	localparam logic [7:0] OP_DIAG_STAT1 = 8'h44;
	localparam logic [7:0] MT_MASK       = 8'h80;
	localparam int         IDX_W         = 10;
	localparam logic [IDX_W-1:0] LEN_COUNT  = 10'h008;
	localparam logic [IDX_W-1:0] LEN_HA     = 10'h005;
	localparam logic [IDX_W-1:0] LEN_DIAG   = 10'h29C;
	localparam logic [IDX_W-1:0] LEN_DSTAT  = 10'h29E;
	localparam logic [IDX_W-1:0] LEN_NONE   = 10'h000;
	localparam logic [IDX_W-1:0] IDX_ZERO   = 10'h000;
	localparam logic [IDX_W-1:0] IDX_ONE    = 10'h001;
	localparam int         DIAG_WORDS    = 668;
	localparam logic [7:0] CORR_BURST_MAX = 8'h0B;
	localparam int         CTRL_START    = 0;
	localparam int         CTRL_SEEK     = 1;
	localparam int         CTRL_READ     = 2;
	localparam int         DRIVE_W       = 3;
	localparam int         NUM_DRIVES    = 8;
	localparam logic [6:0] SECTOR_RESET  = 7'h00;
	localparam logic [7:0] TRACK_RESET   = 8'h00;
	localparam logic [7:0] TRACK_STEP    = 8'h01;
	localparam logic [1:0] RETRY_STEP    = 2'h1;

	typedef enum logic [1:0] {
		DRV_SEEK_HOME,
		DRV_READ_COUNT,
		DRV_READ_HA,
		DRV_READ_R1
	} drce_drv_op_type;

	typedef struct packed {
		logic [7:0]         code;
		logic [DRIVE_W-1:0] drive;
		logic [7:0]         ctrl;
	} drce_cmd_type;

	typedef struct packed {
		logic       parity;
		logic [7:0] data;
	} drce_chan_byte_type;

	typedef struct packed {
		logic retry;
		logic ce;
		logic de;
		logic uc;
	} drce_status_type;
endpackage

// File: tb/drce_exec_asserts.sv
// Port-level assertions for the read command executor
`timescale 1ns/1ps
module drce_exec_asserts (
	input wire logic                         CLK_SYS,
	input wire logic                         RST,
	input wire logic                         CMD_VALID,
	input wire logic                         CMD_READY,
	input wire drce_pkg::drce_cmd_type       CMD,
	input wire logic                         DRV_REQ,
	input wire drce_pkg::drce_drv_op_type    DRV_OP,
	input wire logic                         DRV_MULTI_TRACK,
	input wire logic [7:0]                   ORIENT_VALID,
	input wire logic                         FD_START,
	input wire logic                         FD_SEEK,
	input wire logic                         FD_READ,
	input wire logic [7:0]                   FD_TRACK,
	input wire logic                         CHAN_VALID,
	input wire drce_pkg::drce_chan_byte_type CHAN_BYTE,
	input wire logic                         STAT_VALID,
	input wire drce_pkg::drce_status_type    STAT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Only read count and home address have a multi-track form
	sequence s_take(logic [7:0] c);
		CMD_VALID && CMD_READY && CMD.code == c;
	endsequence
	sequence s_take_mt(logic [7:0] c);
		CMD_VALID && CMD_READY &&
			(CMD.code | drce_pkg::MT_MASK) == (c | drce_pkg::MT_MASK);
	endsequence
	sequence s_stat_end;
		STAT_VALID && STAT.de;
	endsequence
	a_parity_odd:
	assert property (CHAN_VALID |-> CHAN_BYTE.parity == ~^CHAN_BYTE.data)
		else $error("channel byte parity is not odd");
	a_count_issue:
	assert property (s_take_mt(drce_pkg::OP_RD_COUNT) |-> ##2 DRV_REQ
		&& DRV_OP == drce_pkg::DRV_READ_COUNT
		&& DRV_MULTI_TRACK == $past(CMD.code[7], 2))
		else $error("read count not issued to the drive");
	a_ha_issue:
	assert property (s_take_mt(drce_pkg::OP_RD_HA) |-> ##2 DRV_REQ
		&& DRV_OP == drce_pkg::DRV_READ_HA
		&& DRV_MULTI_TRACK == $past(CMD.code[7], 2))
		else $error("home address read not issued to the drive");
	a_sector_byte:
	assert property (s_take(drce_pkg::OP_RD_SECTOR) |-> ##2 CHAN_VALID
		&& !CHAN_BYTE.data[7])
		else $error("sector byte missing or above 127");
	a_orient_clear:
	assert property (s_take(drce_pkg::OP_RD_SECTOR)
		|-> ##2 !ORIENT_VALID[$past(CMD.drive, 2)])
		else $error("orientation kept after sector read");
	a_diag_ce_first:
	assert property (s_take(drce_pkg::OP_DIAG_LOAD)
		|=> STAT_VALID && STAT.ce && !STAT.de)
		else $error("diagnostic load lacks early channel end");
	a_fd_ctrl_follow:
	assert property (s_take(drce_pkg::OP_DIAG_LOAD)
		|=> {FD_READ, FD_SEEK, FD_START} == $past(CMD.ctrl[2:0]))
		else $error("flexible disc lines differ from control byte");
	a_fd_track_step:
	assert property (s_take(drce_pkg::OP_DIAG_LOAD)
		|=> FD_TRACK == $past(FD_TRACK) + 8'h01)
		else $error("flexible disc track did not advance");
	a_uc_with_ends:
	assert property (STAT_VALID && STAT.uc |-> STAT.ce && STAT.de
		&& !STAT.retry)
		else $error("unit check without both ends");
	a_end_drained:
	assert property (s_stat_end |-> !CHAN_VALID)
		else $error("device end while bytes still queued");
endmodule

bind drce_exec drce_exec_asserts drce_exec_asserts_i (
	.CLK_SYS, .RST, .CMD_VALID, .CMD_READY, .CMD, .DRV_REQ, .DRV_OP,
	.DRV_MULTI_TRACK, .ORIENT_VALID, .FD_START, .FD_SEEK, .FD_READ,
	.FD_TRACK, .CHAN_VALID, .CHAN_BYTE, .STAT_VALID, .STAT
);

// File: tb/drce_host.sv
// Host channel model taking bytes with random stalls
`timescale 1ns/1ps
module drce_host (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         stall,
	input  wire logic                         chan_valid,
	input  wire drce_pkg::drce_chan_byte_type chan_byte,
	output logic                              chan_ready,
	output logic                              taken,
	output drce_pkg::drce_chan_byte_type      taken_byte
);
	// Registered ready: a real channel never answers in the same cycle
	always_ff @(posedge clk) begin
		chan_ready <= !rst && !stall;
	end
	assign taken = chan_valid && chan_ready;
	assign taken_byte = chan_byte;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the read command executor
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
	num_errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
	end end
module testbench;
	logic CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, stall = 1'b0;
	logic CMD_VALID, CMD_READY, DRV_REQ, DRV_MULTI_TRACK, DRV_DONE;
	logic INDEX_PIN, DISC_VALID, DISC_READY, AREA_END, AREA_LAST;
	logic ECC_ERR, OVERRUN, RETRY_EN, REC_DONE, REC_MORE_SEGMENTS;
	logic SET_SECTOR_VALID, FD_START, FD_SEEK, FD_READ, FD_VALID;
	logic CHAN_VALID, CHAN_READY, STAT_VALID, taken;
	logic [7:0] DISC_DATA, ECC_BURST, FD_TRACK, FD_DATA, d, code, ctrl;
	logic [7:0] DRIVE_STATUS, CU_STATUS, DRV_POWER_ON, ORIENT_VALID;
	logic [2:0] DRV_SELECT, REC_DRIVE, SET_SECTOR_DRIVE;
	logic [6:0] REC_SECTOR, SET_SECTOR_VALUE, sect, v;
	logic [7:0] rd_codes [4] = '{8'h12, 8'h92, 8'h1A, 8'h9A};
	drce_pkg::drce_cmd_type CMD;
	drce_pkg::drce_drv_op_type DRV_OP;
	drce_pkg::drce_chan_byte_type CHAN_BYTE, taken_byte, exp_b;
	drce_pkg::drce_status_type STAT;
	drce_pkg::drce_chan_byte_type exp_q [$];
	logic [7:0] diag_mem [$];
	int num_errors = 0, check_count = 0, seed = 32'h50D2;

	drce_exec #(.MAX_RETRY(1), .FIFO_DEPTH(8)) drce_exec_i (
		.CLK_SYS, .RST, .CE, .CMD_VALID, .CMD_READY, .CMD, .DRV_REQ,
		.DRV_OP, .DRV_MULTI_TRACK, .DRV_SELECT, .DRV_DONE, .INDEX_PIN,
		.DISC_VALID, .DISC_READY, .DISC_DATA, .AREA_END, .AREA_LAST,
		.ECC_ERR, .ECC_BURST, .OVERRUN, .RETRY_EN, .REC_DONE, .REC_DRIVE,
		.REC_SECTOR, .REC_MORE_SEGMENTS, .SET_SECTOR_VALID,
		.SET_SECTOR_DRIVE, .SET_SECTOR_VALUE, .DRV_POWER_ON, .ORIENT_VALID,
		.FD_START, .FD_SEEK, .FD_READ, .FD_TRACK, .FD_VALID, .FD_DATA,
		.DRIVE_STATUS, .CU_STATUS, .CHAN_VALID, .CHAN_READY, .CHAN_BYTE,
		.STAT_VALID, .STAT);
	drce_host drce_host_i (.clk(CLK_SYS), .rst(RST), .stall,
		.chan_valid(CHAN_VALID), .chan_byte(CHAN_BYTE),
		.chan_ready(CHAN_READY), .taken, .taken_byte);

	always #5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) stall <= ($random(seed) & 3) == 0;
	always @(posedge CLK_SYS) begin
		if (taken) begin
			exp_b = exp_q.size() ? exp_q.pop_front() : 'x;
			`CHK(taken_byte, exp_b)
		end
	end

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [2:0] drv,
			input logic [7:0] k);
		int n = 0;
		@(posedge CLK_SYS);
		CMD_VALID <= 1'b1;
		CMD <= '{code: c, drive: drv, ctrl: k};
		do @(negedge CLK_SYS); while (!CMD_READY && ++n < 5000);
		if (n >= 5000) num_errors++;
		@(posedge CLK_SYS);
		CMD_VALID <= 1'b0;
		CMD <= ~CMD;
	endtask
	task automatic wait_stat(input drce_pkg::drce_status_type e);
		int n = 0;
		do @(negedge CLK_SYS); while (!STAT_VALID && ++n < 5000);
		`CHK(STAT, e)
	endtask
	task automatic wait_drv(input drce_pkg::drce_drv_op_type op);
		int n = 0;
		do @(negedge CLK_SYS); while (!DRV_REQ && ++n < 5000);
		if (n >= 5000) num_errors++;
		`CHK(DRV_OP, op)
	endtask
	// Drive bytes beyond the command count are sent but must be dropped
	task automatic feed(input int n, input int fwd, input logic err,
			input logic ovr, input logic [7:0] burst);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			if (i < fwd) exp_q.push_back({~^d, d});
			@(posedge CLK_SYS);
			DISC_VALID <= 1'b1;
			DISC_DATA <= d;
			OVERRUN <= ovr && i == 1;
			do @(negedge CLK_SYS); while (!DISC_READY);
		end
		@(posedge CLK_SYS);
		{DISC_VALID, OVERRUN, DISC_DATA} <= {2'h0, ~d};
		{AREA_END, AREA_LAST, ECC_ERR, ECC_BURST} <= {2'h3, err, burst};
		@(posedge CLK_SYS);
		{AREA_END, AREA_LAST, ECC_ERR} <= 3'h0;
	endtask

	initial begin
		#400000;
		num_errors++;
		conclude();
	end
	initial begin
		{CMD_VALID, DRV_DONE, INDEX_PIN, DISC_VALID, AREA_END} = '0;
		{AREA_LAST, ECC_ERR, OVERRUN, RETRY_EN, REC_DONE} = '0;
		{REC_MORE_SEGMENTS, SET_SECTOR_VALID, FD_VALID, CMD} = '0;
		{DISC_DATA, ECC_BURST, FD_DATA, DRV_POWER_ON} = '0;
		{REC_DRIVE, SET_SECTOR_DRIVE, REC_SECTOR, SET_SECTOR_VALUE} = 20'h6C000;
		DRIVE_STATUS = 8'($random(seed));
		CU_STATUS = 8'($random(seed));
		repeat (8) @(posedge CLK_SYS);
		RST <= 1'b0;
		RETRY_EN <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			code = rd_codes[k];
			cmd(code, 3'(k), 8'h00);
			wait_drv(code[3] ? drce_pkg::DRV_READ_HA :
				drce_pkg::DRV_READ_COUNT);
			`CHK(DRV_MULTI_TRACK, code[7])
			feed(10, code[3] ? 5 : 8, 1'b0, 1'b0, 8'h00);
			wait_stat(4'h6);
			`CHK(exp_q.size(), 0)
		end
		cmd(8'h92, 3'h1, 8'h00);
		wait_drv(drce_pkg::DRV_READ_COUNT);
		feed(10, 8, 1'b1, 1'b0, 8'h20);
		wait_stat(4'h8);
		wait_drv(drce_pkg::DRV_READ_COUNT);
		feed(10, 8, 1'b1, 1'b0, 8'h20);
		wait_stat(4'h7);
		// Top bit set on a code without a multi-track form is refused
		cmd(8'hA2, 3'h0, 8'h00);
		wait_stat(4'h7);
		cmd(drce_pkg::OP_RD_IPL, 3'h2, 8'h00);
		wait_drv(drce_pkg::DRV_SEEK_HOME);
		`CHK(DRV_SELECT, 3'h2)
		@(posedge CLK_SYS);
		DRV_DONE <= 1'b1;
		@(posedge CLK_SYS);
		{DRV_DONE, INDEX_PIN} <= 2'h1;
		repeat (4) @(posedge CLK_SYS);
		INDEX_PIN <= 1'b0;
		wait_drv(drce_pkg::DRV_READ_R1);
		feed(6, 6, 1'b1, 1'b0, 8'h0B);
		wait_stat(4'h7);
		@(posedge CLK_SYS);
		RETRY_EN <= 1'b0;
		cmd(drce_pkg::OP_RD_HA, 3'h4, 8'h00);
		wait_drv(drce_pkg::DRV_READ_HA);
		feed(7, 5, 1'b0, 1'b1, 8'h00);
		wait_stat(4'h7);
		// Set, final segment, non-final segment, set, power-on, none
		for (int k = 0; k < 6; k++) begin
			v = 7'($random(seed));
			@(posedge CLK_SYS);
			SET_SECTOR_VALID <= k == 0 || k == 3;
			REC_DONE <= k == 1 || k == 2;
			REC_MORE_SEGMENTS <= k == 2;
			DRV_POWER_ON <= {4'h0, k == 4, 3'h0};
			{SET_SECTOR_VALUE, REC_SECTOR} <= {v, v};
			if (k == 0 || k == 1 || k == 3) sect = v;
			if (k == 4) sect = 7'h00;
			@(posedge CLK_SYS);
			{SET_SECTOR_VALID, REC_DONE, REC_MORE_SEGMENTS} <= 3'h0;
			DRV_POWER_ON <= 8'h00;
			exp_q.push_back({~^{1'b0, sect}, 1'b0, sect});
			cmd(drce_pkg::OP_RD_SECTOR, 3'h3, 8'h00);
			wait_stat(4'h6);
			`CHK(exp_q.size(), 0)
		end
		// A system reset wipes a sector value loaded just before it
		@(posedge CLK_SYS);
		{SET_SECTOR_VALID, SET_SECTOR_VALUE} <= 8'hD5;
		@(posedge CLK_SYS);
		{SET_SECTOR_VALID, RST} <= 2'h1;
		@(posedge CLK_SYS);
		RST <= 1'b0;
		exp_q.push_back({1'b1, 8'h00});
		cmd(drce_pkg::OP_RD_SECTOR, 3'h3, 8'h00);
		wait_stat(4'h6);
		`CHK(exp_q.size(), 0)
		for (int k = 0; k < 2; k++) begin
			ctrl = k ? 8'h02 : 8'h05;
			cmd(drce_pkg::OP_DIAG_LOAD, 3'h0, ctrl);
			wait_stat(4'h4);
			`CHK({FD_READ, FD_SEEK, FD_START}, ctrl[2:0])
			`CHK(FD_TRACK, 8'(k + 1))
			diag_mem.delete();
			while (diag_mem.size() < drce_pkg::DIAG_WORDS) begin
				d = 8'($random(seed));
				@(posedge CLK_SYS);
				FD_VALID <= d[0] | d[1];
				FD_DATA <= d;
				if (d[0] | d[1]) diag_mem.push_back(d);
			end
			@(posedge CLK_SYS);
			{FD_VALID, FD_DATA} <= {1'b0, ~d};
			wait_stat(4'h2);
			foreach (diag_mem[i]) exp_q.push_back({~^diag_mem[i], diag_mem[i]});
			exp_q.push_back({~^DRIVE_STATUS, DRIVE_STATUS});
			exp_q.push_back({~^CU_STATUS, CU_STATUS});
			cmd(drce_pkg::OP_DIAG_STAT1, 3'h0, 8'h00);
			wait_stat(4'h6);
			`CHK(exp_q.size(), 0)
		end
		conclude();
	end
endmodule
